/* File: include/mxio_pkg.sv */
package mxio_pkg;
  // ==========================================================
  // input vector layout after conditioning
  localparam int IN_W = 17;
  localparam int IB_EXT = 0;
  localparam int IB_PHOTO = 1;
  localparam int IB_CLR = 2;
  localparam int IB_ENCA = 3;
  localparam int IB_ENCB = 4;
  localparam int IB_GP = 5;
  localparam int GP_W = 12;
  localparam int MSG_W = 8;
  localparam int DLY_W_DEF = 24;
  localparam int IRQ_W = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_STOP = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_POS = 8'h10;
  localparam logic [7:0] OFF_IRQ_ST = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

  // control fields
  localparam int CB_TRIG_SRC = 0;
  localparam int CB_ENC_MODE = 1;
  localparam int CB_BOOT = 2;

  // status fields
  localparam int SB_READY = 0;
  localparam int SB_MARK = 1;
  localparam int SB_DONE = 2;
  localparam int SB_BOOT = 3;
  localparam int SB_ALARM = 4;
  localparam int SB_BUSY = 5;
  localparam int SB_MSG = 8;

  // interrupt status / mask fields
  localparam int IQ_TRIG = 0;
  localparam int IQ_DONE = 1;
  localparam int IQ_STOP = 2;
  localparam int IQ_ALARM = 3;
  localparam int IQ_CLEAR = 4;

  // reset values
  localparam logic [GP_W-1:0] STOP_RST = 12'h000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  // ==========================================================
  // timing
  localparam int CLK_NS = 5;
  localparam int DEB_TIME_NS = 20;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_MARK} mxio_state_t;
endpackage : mxio_pkg

/* File: include/mxio_cond_if.sv */
`timescale 1ns/1ps
// conditioned inputs passed from the input stage to the control core
interface mxio_cond_if;
  logic [mxio_pkg::IN_W-1:0] level;
  logic [mxio_pkg::IN_W-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface : mxio_cond_if

/* File: design/mxio_in_cond.sv */
`timescale 1ns/1ps
module mxio_in_cond #(
  parameter int DEB_CYCLES = mxio_pkg::DEB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [mxio_pkg::IN_W-1:0] raw,
  mxio_cond_if.src cond
);
  import mxio_pkg::*;

  localparam int CW = $clog2(DEB_CYCLES + 1);

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] stab;
    logic [IN_W-1:0] rise;
    logic [IN_W-1:0][CW-1:0] cnt;
  } mxio_cond_st_t;

  mxio_cond_st_t q;
  mxio_cond_st_t d;
  wire [IN_W-1:0] stab_n;
  wire [IN_W-1:0] rise_n;
  wire [IN_W-1:0][CW-1:0] cnt_n;

  // ==========================================================
  // per-bit debounce: level must disagree for DEB_CYCLES in a row
  genvar i;
  generate
    for (i = 0; i < IN_W; i++) begin : g_bit
      wire settled = (q.s2[i] == q.stab[i]);
      wire expired = (q.cnt[i] == CW'(DEB_CYCLES - 1));
      assign cnt_n[i] = (settled || expired) ? '0 : q.cnt[i] + CW'(1);
      assign stab_n[i] = (!settled && expired) ? q.s2[i] : q.stab[i];
      assign rise_n[i] = !settled && expired && q.s2[i];
    end
  endgenerate

  // s1 feeds only s2, nothing else looks at it
  always_comb begin
    d.s1 = raw;
    d.s2 = q.s1;
    d.stab = stab_n;
    d.rise = rise_n;
    d.cnt = cnt_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cond.level = q.stab;
  assign cond.rise = q.rise;

  // ==========================================================
  // checks
  chk_rise_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    |cond.rise |-> ((cond.level & cond.rise) == cond.rise) && (($past(q.stab) & cond.rise) == '0))
    else $error("edge pulse without settled high level");
endmodule : mxio_in_cond

/* File: design/mxio_top.sv */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - line-controller trigger only when source selects it
// - fault clear after alarm release restores ready
// - ready held high during print-ready mode
// - done output set when marking completes
// - marking output high for whole marking
// - boot-ok high once initialisation completes
// - alarm output high while alarm active
// - general bits 0-7 carry message code
// - any mapped stop bit halts marking
// - per-bit function chosen by setup register
// - programmable delay from trigger to marking
// - encoder steps pace the delay
// - message code is unsigned, bit 0 lsb
module mxio_top #(
  parameter int DLY_W = mxio_pkg::DLY_W_DEF,
  parameter int DEB_CYCLES = mxio_pkg::DEB_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_print_trigger,
  input wire logic photocell_in,
  input wire logic fault_clear_input,
  input wire logic encoder_phase_a,
  input wire logic encoder_phase_b,
  input wire logic [mxio_pkg::GP_W-1:0] gen_in,
  input wire logic alarm_cond,
  input wire logic engine_done,
  output logic print_ready_output,
  output logic print_done_output,
  output logic marking_active_output,
  output logic boot_ok_output,
  output logic alarm_output,
  output logic mark_start,
  output logic mark_abort,
  output logic [mxio_pkg::MSG_W-1:0] msg_select,
  output logic [31:0] enc_position,
  output logic irq
);
  import mxio_pkg::*;

  typedef struct packed {
    mxio_state_t st;
    logic trig_src;
    logic enc_mode;
    logic boot;
    logic [DLY_W-1:0] delay;
    logic [DLY_W-1:0] dcnt;
    logic [GP_W-1:0] stop_mask;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic alarm;
    logic done;
    logic start;
    logic abort;
    logic [MSG_W-1:0] msg;
    logic [31:0] pos;
    logic [1:0] enc_prev;
    logic [31:0] rdata;
  } mxio_top_st_t;

  localparam mxio_top_st_t ST_RST = '{
    st: ST_IDLE,
    trig_src: 1'b0,
    enc_mode: 1'b0,
    boot: 1'b0,
    delay: '0,
    dcnt: '0,
    stop_mask: STOP_RST,
    irq_st: '0,
    irq_mask: IRQ_MASK_RST,
    alarm: 1'b0,
    done: 1'b0,
    start: 1'b0,
    abort: 1'b0,
    msg: '0,
    pos: POS_RST,
    enc_prev: 2'h0,
    rdata: 32'h0000_0000
  };

  mxio_top_st_t q;
  mxio_top_st_t d;

  // ==========================================================
  // input conditioning
  mxio_cond_if cond_bus ();

  mxio_in_cond #(
    .DEB_CYCLES(DEB_CYCLES)
  ) u_cond (
    .pclk(pclk),
    .presetn(presetn),
    .raw({gen_in, encoder_phase_b, encoder_phase_a, fault_clear_input,
          photocell_in, external_print_trigger}),
    .cond(cond_bus.src)
  );

  logic enc_a;
  logic enc_b;
  logic step;
  logic step_up;
  logic stop_any;
  logic trig_rise;
  logic ready;
  logic setup_ph;
  logic rd_acc;
  logic wr_acc;
  logic mapped;
  logic [31:0] rmux;
  logic [31:0] stat_w;
  logic [IRQ_W-1:0] ev;

  // ==========================================================
  // quadrature: one phase change per step, a double change is dropped
  assign enc_a = cond_bus.level[IB_ENCA];
  assign enc_b = cond_bus.level[IB_ENCB];
  assign step = (enc_a ^ q.enc_prev[1]) ^ (enc_b ^ q.enc_prev[0]);
  assign step_up = enc_a ^ q.enc_prev[0];

  // stop bits are whichever general inputs setup maps to stop
  assign stop_any = |(cond_bus.level[IB_GP +: GP_W] & q.stop_mask);
  assign trig_rise = q.trig_src ? cond_bus.rise[IB_EXT] : cond_bus.rise[IB_PHOTO];
  // ready mode: initialised and no alarm latched
  assign ready = q.boot & ~q.alarm;

  // apb phases
  assign setup_ph = psel & ~penable;
  assign rd_acc = psel & penable & ~pwrite;
  assign wr_acc = psel & penable & pwrite;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.enc_prev = {enc_a, enc_b};
    ev = '0;

    // status word
    stat_w = 32'h0000_0000;
    stat_w[SB_READY] = ready;
    stat_w[SB_MARK] = (q.st == ST_MARK);
    stat_w[SB_DONE] = q.done;
    stat_w[SB_BOOT] = q.boot;
    stat_w[SB_ALARM] = q.alarm;
    stat_w[SB_BUSY] = (q.st != ST_IDLE);
    stat_w[SB_MSG +: MSG_W] = q.msg;

    // read decode
    mapped = 1'b1;
    rmux = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL: begin
        rmux[CB_TRIG_SRC] = q.trig_src;
        rmux[CB_ENC_MODE] = q.enc_mode;
        rmux[CB_BOOT] = q.boot;
      end
      OFF_DELAY: rmux[DLY_W-1:0] = q.delay;
      OFF_STOP: rmux[GP_W-1:0] = q.stop_mask;
      OFF_STATUS: rmux = stat_w;
      OFF_POS: rmux = q.pos;
      OFF_IRQ_ST: rmux[IRQ_W-1:0] = q.irq_st;
      OFF_IRQ_MASK: rmux[IRQ_W-1:0] = q.irq_mask;
      default: mapped = 1'b0;
    endcase
    // read data captured in setup so prdata comes from a flop
    if (setup_ph) begin
      d.rdata = rmux;
    end

    // position follows the conveyor in both directions
    if (step) begin
      d.pos = step_up ? q.pos + 32'h0000_0001 : q.pos - 32'h0000_0001;
    end

    // alarm latch: released only by fault clear once condition is gone
    if (alarm_cond) begin
      d.alarm = 1'b1;
      ev[IQ_ALARM] = ~q.alarm;
    end else if (q.alarm && cond_bus.rise[IB_CLR]) begin
      d.alarm = 1'b0;
      ev[IQ_CLEAR] = 1'b1;
    end

    // print sequence
    unique case (q.st)
      ST_IDLE: begin
        if (ready && trig_rise && !stop_any) begin
          d.st = ST_DELAY;
          d.dcnt = q.delay;
          // stop-mapped bits read as zero in the code
          // unsigned table position, general bit 0 is the lsb
          d.msg = cond_bus.level[IB_GP +: MSG_W] & ~q.stop_mask[MSG_W-1:0];
          d.done = 1'b0;
          ev[IQ_TRIG] = 1'b1;
        end
      end
      ST_DELAY: begin
        if (stop_any || alarm_cond) begin
          d.st = ST_IDLE;
          d.abort = 1'b1;
          ev[IQ_STOP] = stop_any;
        end else if (q.dcnt == '0) begin
          d.st = ST_MARK;
          d.start = 1'b1;
        end else if (!q.enc_mode || step) begin
          // encoder mode counts conveyor steps, not clock cycles
          d.dcnt = q.dcnt - DLY_W'(1);
        end
      end
      ST_MARK: begin
        if (stop_any || alarm_cond) begin
          d.st = ST_IDLE;
          d.abort = 1'b1;
          ev[IQ_STOP] = stop_any;
        end else if (engine_done) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
          ev[IQ_DONE] = 1'b1;
        end
      end
    endcase

    // register writes
    if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: begin
          d.trig_src = pwdata[CB_TRIG_SRC];
          d.enc_mode = pwdata[CB_ENC_MODE];
          d.boot = q.boot | pwdata[CB_BOOT];
        end
        OFF_DELAY: d.delay = pwdata[DLY_W-1:0];
        OFF_STOP: d.stop_mask = pwdata[GP_W-1:0];
        OFF_IRQ_MASK: d.irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // read clears only what was returned; a new event still wins
    if (rd_acc && paddr == OFF_IRQ_ST) begin
      d.irq_st = q.irq_st & ~q.rdata[IRQ_W-1:0];
    end
    d.irq_st = d.irq_st | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign print_ready_output = ready;
  assign print_done_output = q.done;
  assign marking_active_output = (q.st == ST_MARK);
  assign boot_ok_output = q.boot;
  assign alarm_output = q.alarm;
  assign mark_start = q.start;
  assign mark_abort = q.abort;
  assign msg_select = q.msg;
  assign enc_position = q.pos;
  assign irq = |(q.irq_st & q.irq_mask);

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_trig_source: assert property (
    (q.st == ST_IDLE) && !q.trig_src && cond_bus.rise[IB_EXT] && !cond_bus.rise[IB_PHOTO]
    |=> (q.st == ST_IDLE))
    else $error("line trigger taken while photocell selected");

  chk_ready_return: assert property (
    q.alarm && !alarm_cond && cond_bus.rise[IB_CLR] && q.boot |=> print_ready_output)
    else $error("fault clear did not restore ready");

  chk_ready_alarm: assert property (
    alarm_cond |=> !print_ready_output ##1 (!print_ready_output || !alarm_output))
    else $error("ready high during alarm");

  chk_done_set: assert property (
    (q.st == ST_MARK) && engine_done && !stop_any && !alarm_cond
    |=> print_done_output && !marking_active_output)
    else $error("done not raised at end of marking");

  chk_marking_span: assert property (
    mark_start |-> marking_active_output && $past(q.st == ST_DELAY))
    else $error("start pulse outside marking");

  chk_boot_sticky: assert property (
    boot_ok_output |=> boot_ok_output [*4])
    else $error("boot-ok dropped");

  chk_alarm_follow: assert property (
    alarm_cond |=> alarm_output)
    else $error("alarm output not set");

  chk_msg_hold: assert property (
    (q.st != ST_IDLE) && $past(q.st != ST_IDLE) |-> $stable(msg_select))
    else $error("message code moved during marking");

  chk_msg_code: assert property (
    (q.st == ST_IDLE) && ready && trig_rise && !stop_any
    |=> msg_select == $past(cond_bus.level[IB_GP +: MSG_W] & ~q.stop_mask[MSG_W-1:0]))
    else $error("latched message code wrong");

  chk_stop_halt: assert property (
    (q.st != ST_IDLE) && stop_any |=> (q.st == ST_IDLE) && mark_abort && !marking_active_output)
    else $error("stop input did not halt marking");

  chk_delay_time: assert property (
    (q.st == ST_DELAY) && !q.enc_mode && !stop_any && !alarm_cond && q.dcnt == DLY_W'(2)
    ##1 (!stop_any && !alarm_cond) [*2] |=> mark_start)
    else $error("start delay length wrong");

  chk_enc_count: assert property (
    step |=> enc_position == ($past(step_up) ? $past(q.pos) + 32'h1 : $past(q.pos) - 32'h1))
    else $error("encoder position miscounted");

  cov_trigger: cover property ((q.st == ST_IDLE) ##1 (q.st == ST_DELAY));
  cov_complete: cover property (mark_start ##[1:50] print_done_output);
  cov_stop: cover property ((q.st == ST_MARK) ##1 mark_abort);
  cov_alarm_clear: cover property (alarm_output ##[1:100] !alarm_output);
endmodule : mxio_top

/* File: testbench/mxio_line_model.sv */
`timescale 1ns/1ps
// =====================================================
// line side: controller, photocell, encoder and marking engine
module mxio_line_model #(
  parameter int PWR_CYC = 16,
  parameter int HOLD = 8
) (
  input wire logic pclk,
  input wire logic mark_start,
  output logic external_print_trigger,
  output logic photocell_in,
  output logic fault_clear_input,
  output logic encoder_phase_a,
  output logic encoder_phase_b,
  output logic [mxio_pkg::GP_W-1:0] gen_in,
  output logic alarm_cond,
  output logic engine_done
);
  import mxio_pkg::*;
  int eng_lat = 4;
  int cyc = 0;
  int ph = 0;
  int eng_cnt = 0;

  // everything idle low until the first request
  initial begin
    {external_print_trigger, photocell_in, fault_clear_input} = 3'b000;
    {encoder_phase_a, encoder_phase_b, alarm_cond, engine_done} = 4'h0;
    gen_in = '0;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  // set_lines and trig drive nothing until the power-up settle time has run out
  task automatic powered;
    while (cyc < PWR_CYC) @(posedge pclk);
  endtask : powered

  // controller sets message code, stop bits and the alarm condition
  task automatic set_lines(input logic [GP_W-1:0] g, input logic a);
    powered();
    gen_in <= g;
    alarm_cond <= a;
    @(posedge pclk);
  endtask : set_lines

  // held well past the debounce, so a short glitch is never the cause
  task automatic trig(input int src);
    powered();
    if (src == 1) external_print_trigger <= 1'b1;
    else if (src == 0) photocell_in <= 1'b1;
    else fault_clear_input <= 1'b1;
    repeat (HOLD) @(posedge pclk);
    {external_print_trigger, photocell_in, fault_clear_input} <= 3'b000;
    repeat (HOLD) @(posedge pclk);
  endtask : trig

  // one quadrature step, a leads b when counting up
  task automatic enc_step(input int up);
    ph = (ph + (up != 0 ? 1 : 3)) % 4;
    encoder_phase_a <= (ph == 1 || ph == 2);
    encoder_phase_b <= (ph >= 2);
    repeat (HOLD) @(posedge pclk);
  endtask : enc_step

  // engine finishes eng_lat cycles after the start pulse
  always @(posedge pclk) begin
    engine_done <= 1'b0;
    if (mark_start === 1'b1) eng_cnt <= eng_lat;
    else if (eng_cnt > 0) begin
      eng_cnt <= eng_cnt - 1;
      if (eng_cnt == 1) engine_done <= 1'b1;
    end
  end
endmodule : mxio_line_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  import mxio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, enc_position, rd;
  logic external_print_trigger, photocell_in, fault_clear_input;
  logic encoder_phase_a, encoder_phase_b, alarm_cond, engine_done;
  logic [GP_W-1:0] gen_in;
  logic print_ready_output, print_done_output, marking_active_output;
  logic boot_ok_output, alarm_output, mark_start, mark_abort, err;
  logic [MSG_W-1:0] msg_select;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_start = 0;
  int n_abort = 0;
  int t_start = 0;
  int t0, d3, ns;

  // =====================================================
  // design and line side
  mxio_top #(.DEB_CYCLES(1)) u_mxio_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_print_trigger(external_print_trigger), .photocell_in(photocell_in),
    .fault_clear_input(fault_clear_input), .encoder_phase_a(encoder_phase_a),
    .encoder_phase_b(encoder_phase_b), .gen_in(gen_in), .alarm_cond(alarm_cond),
    .engine_done(engine_done), .print_ready_output(print_ready_output),
    .print_done_output(print_done_output), .marking_active_output(marking_active_output),
    .boot_ok_output(boot_ok_output), .alarm_output(alarm_output), .mark_start(mark_start),
    .mark_abort(mark_abort), .msg_select(msg_select), .enc_position(enc_position),
    .irq(irq));
  mxio_line_model u_mxio_line_model (
    .pclk(pclk), .mark_start(mark_start), .external_print_trigger(external_print_trigger),
    .photocell_in(photocell_in), .fault_clear_input(fault_clear_input),
    .encoder_phase_a(encoder_phase_a), .encoder_phase_b(encoder_phase_b), .gen_in(gen_in),
    .alarm_cond(alarm_cond), .engine_done(engine_done));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // start pulses are one cycle wide, so count them as they pass
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mark_start === 1'b1) begin
      n_start <= n_start + 1;
      t_start <= cyc;
    end
    if (mark_abort === 1'b1) n_abort <= n_abort + 1;
  end

  // =====================================================
  // bus and wait helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed wait count: only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle cycle keeps one assignment per time step
  endtask : apb

  task automatic wait_start(input int n0);
    for (int k = 0; k < 300 && n_start == n0; k++) @(posedge pclk);
  endtask : wait_start

  task automatic wait_idle;
    for (int k = 0; k < 300 && marking_active_output !== 1'b0; k++) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask : wait_idle

  task automatic test_done;
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done();
  end

  // =====================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h1c, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    `CHK(pready, 1'b1)
    `CHK({boot_ok_output, print_ready_output}, 2'b00)
    apb(1'b1, OFF_CTRL, 32'h5);
    apb(1'b1, OFF_DELAY, 32'h3);
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    `CHK({boot_ok_output, print_ready_output}, 2'b11)
    // photocell ignored while the controller is the source
    u_mxio_line_model.set_lines(12'h0a5, 1'b0);
    u_mxio_line_model.trig(0);
    repeat (20) @(posedge pclk);
    `CHK(n_start, 0)
    u_mxio_line_model.eng_lat = 10;
    t0 = cyc;
    u_mxio_line_model.trig(1);
    wait_start(0);
    d3 = t_start - t0;
    `CHK(marking_active_output, 1'b1)
    `CHK(msg_select, 8'ha5)
    u_mxio_line_model.set_lines(12'h05a, 1'b0);
    `CHK({marking_active_output, msg_select}, 9'h1a5)
    wait_idle();
    `CHK({print_done_output, irq}, 2'b11)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0000_a50d)
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK(rd, 32'h3)
    `CHK(irq, 1'b0)
    // photocell source, longer delay shifts the start by the difference
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b1, OFF_DELAY, 32'h9);
    // line-controller trigger ignored while the photocell is the source
    u_mxio_line_model.trig(1);
    `CHK(n_start, 1)
    u_mxio_line_model.eng_lat = 2;
    t0 = cyc;
    u_mxio_line_model.trig(0);
    wait_start(1);
    `CHK(t_start - t0 - d3, 6)
    `CHK(msg_select, 8'h5a)
    wait_idle();
    // encoder mode: delay counts steps, not clocks
    apb(1'b1, OFF_CTRL, 32'h6);
    apb(1'b1, OFF_DELAY, 32'h2);
    u_mxio_line_model.enc_step(1);
    `CHK(enc_position, 32'h1)
    u_mxio_line_model.trig(0);
    repeat (20) @(posedge pclk);
    u_mxio_line_model.enc_step(1);
    `CHK(n_start, 2)
    u_mxio_line_model.enc_step(1);
    `CHK(n_start, 3)
    u_mxio_line_model.enc_step(0);
    apb(1'b0, OFF_POS, 32'h0);
    `CHK(rd, 32'h2)
    wait_idle();
    // stop bit 9 aborts the delay and then blocks a new trigger
    apb(1'b1, OFF_CTRL, 32'h4);
    apb(1'b1, OFF_DELAY, 32'd30);
    apb(1'b1, OFF_STOP, 32'h200);
    u_mxio_line_model.set_lines(12'h03c, 1'b0);
    ns = n_start;
    u_mxio_line_model.trig(0);
    u_mxio_line_model.set_lines(12'h23c, 1'b0);
    repeat (10) @(posedge pclk);
    `CHK(n_abort, 1)
    u_mxio_line_model.trig(0);
    repeat (40) @(posedge pclk);
    `CHK(n_start - ns, 0)
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK(rd, 32'h7)
    u_mxio_line_model.set_lines(12'h000, 1'b0);
    // alarm latches until cleared after release
    u_mxio_line_model.set_lines(12'h000, 1'b1);
    repeat (2) @(posedge pclk);
    `CHK({alarm_output, print_ready_output}, 2'b10)
    u_mxio_line_model.trig(2);
    `CHK(alarm_output, 1'b1)
    u_mxio_line_model.set_lines(12'h000, 1'b0);
    u_mxio_line_model.trig(2);
    `CHK({alarm_output, print_ready_output}, 2'b01)
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    `CHK(rd, 32'h18)
    test_done();
  end
endmodule : testbench
